// ==== wtse_pkg.sv ====
package wtse_pkg;

  localparam int AW = 16;
  localparam int DW = 16;

  // Operation codes decoded by the sequencer.
  localparam logic [2:0] OP_DEFINE = 3'h0;
  localparam logic [2:0] OP_PUSH   = 3'h1;
  localparam logic [2:0] OP_LIFO   = 3'h2;
  localparam logic [2:0] OP_FIFO   = 3'h3;
  localparam logic [2:0] OP_SEARCH = 3'h4;
  localparam logic [2:0] OP_MAX    = 3'h5;

  // Stack layout relative to the base word.
  localparam logic [15:0] PTR_OFS   = 16'h0001;
  localparam logic [15:0] FIRST_OFS = 16'h0002;

  // Control word fields for find-maximum.
  localparam int CTL_SIGNED_BIT = 15;
  localparam int CTL_INDEX_BIT  = 14;
  localparam logic [15:0] CTL_LEN_MASK = 16'h0FFF;

  // Register port map, byte offsets.
  localparam logic [3:0] REG_CTRL  = 4'h0;
  localparam logic [3:0] REG_STAT  = 4'h4;
  localparam logic [3:0] REG_INDEX = 4'h8;
  localparam logic       CTRL_RST  = 1'b1;
  localparam int STAT_MATCH_BIT = 0;
  localparam int STAT_BUSY_BIT  = 1;

  typedef enum logic [4:0] {
    S_IDLE  = 5'h00,
    S_ZERO  = 5'h01,
    S_WBASE = 5'h03,
    S_WPTR  = 5'h02,
    S_DONE  = 5'h06,
    S_RWAIT = 5'h07,
    S_GPTR  = 5'h05,
    S_PUSHW = 5'h04,
    S_GDAT  = 5'h0C,
    S_WDEST = 5'h0D,
    S_GBASE = 5'h0F,
    S_SHG   = 5'h0E,
    S_SHW   = 5'h0A,
    S_WZERO = 5'h0B,
    S_SCAN  = 5'h09,
    S_SGET  = 5'h08,
    S_SHN   = 5'h19,
    S_MAXW  = 5'h18
  } wtse_state_t;

  // Four-digit BCD to binary.
  function automatic logic [15:0] wtse_bcd(input logic [15:0] b);
    logic [15:0] r;
    r = 16'({12'h000, b[15:12]}) * 16'h03E8;
    r = r + 16'({12'h000, b[11:8]}) * 16'h0064;
    r = r + 16'({12'h000, b[7:4]}) * 16'h000A;
    r = r + {12'h000, b[3:0]};
    return r;
  endfunction : wtse_bcd

endpackage : wtse_pkg

// ==== wtse_engine.sv ====
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module wtse_engine
  import wtse_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic          rst_n_i,
  input  wire logic          start_i,
  input  wire logic [2:0]    op_i,
  input  wire logic [AW-1:0] table_base_i,
  input  wire logic [15:0]   length_i,
  input  wire logic [DW-1:0] source_i,
  input  wire logic [AW-1:0] range_origin_i,
  input  wire logic [DW-1:0] compare_value_i,
  input  wire logic [15:0]   control_i,
  input  wire logic [AW-1:0] dest_addr_i,
  output logic               busy_o,
  output logic               done_o,
  output logic [AW-1:0]      mem_addr_o,
  output logic [DW-1:0]      mem_wdata_o,
  output logic               mem_we_o,
  output logic               mem_re_o,
  input  wire logic [DW-1:0] mem_rdata_i,
  output logic               match_flag_o,
  output logic [AW-1:0]      index_o,
  input  wire logic [3:0]    reg_addr_i,
  input  wire logic [15:0]   reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic [15:0]        reg_rdata_o
);

  wtse_state_t   state_r;
  wtse_state_t   ret_r;
  logic [2:0]    op_r;
  logic [AW-1:0] tb_r;
  logic [AW-1:0] last_r;
  logic [AW-1:0] ptr_r;
  logic [AW-1:0] cnt_r;
  logic [AW-1:0] org_r;
  logic [AW-1:0] dest_r;
  logic [15:0]   n_r;
  logic [DW-1:0] src_r;
  logic [DW-1:0] cmp_r;
  logic [DW-1:0] data_r;
  logic [DW-1:0] best_r;
  logic [AW-1:0] best_idx_r;
  logic          found_r;
  logic          signed_r;
  logic          wr_idx_r;
  logic          idx_ld_r;
  logic          flag_ld_r;
  logic          enable_r;
  logic [AW-1:0] scan_addr;
  logic          greater;

  // Address of the word now returning during a scan.
  assign scan_addr = org_r + cnt_r;
  // Maximum comparison; strict so that ties keep the lowest address.
  assign greater = signed_r ? ($signed(mem_rdata_i) > $signed(best_r))
                            : (mem_rdata_i > best_r);

  // Sequencer for every operation; memory strobes are registered, so
  // each access appears on the port one cycle after it is decided and
  // read data is taken in the state that the wait state returns to.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r     <= S_IDLE;
      ret_r       <= S_IDLE;
      op_r        <= OP_DEFINE;
      tb_r        <= '0;
      last_r      <= '0;
      ptr_r       <= '0;
      cnt_r       <= '0;
      org_r       <= '0;
      dest_r      <= '0;
      n_r         <= '0;
      src_r       <= '0;
      cmp_r       <= '0;
      data_r      <= '0;
      best_r      <= '0;
      best_idx_r  <= '0;
      found_r     <= 1'b0;
      signed_r    <= 1'b0;
      wr_idx_r    <= 1'b0;
      idx_ld_r    <= 1'b0;
      flag_ld_r   <= 1'b0;
      busy_o      <= 1'b0;
      done_o      <= 1'b0;
      mem_addr_o  <= '0;
      mem_wdata_o <= '0;
      mem_we_o    <= 1'b0;
      mem_re_o    <= 1'b0;
    end else begin
      mem_we_o  <= 1'b0;
      mem_re_o  <= 1'b0;
      done_o    <= 1'b0;
      idx_ld_r  <= 1'b0;
      flag_ld_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (start_i && enable_r) begin
            busy_o   <= 1'b1;
            op_r     <= op_i;
            tb_r     <= table_base_i;
            src_r    <= source_i;
            org_r    <= range_origin_i;
            cmp_r    <= compare_value_i;
            dest_r   <= dest_addr_i;
            signed_r <= control_i[CTL_SIGNED_BIT];
            wr_idx_r <= control_i[CTL_INDEX_BIT];
            found_r  <= 1'b0;
            cnt_r    <= '0;
            case (op_i)
              OP_DEFINE: begin
                cnt_r   <= table_base_i + FIRST_OFS;
                ptr_r   <= table_base_i + FIRST_OFS;
                last_r  <= table_base_i + wtse_bcd(length_i) - 16'h0001;
                state_r <= S_ZERO;
              end
              OP_PUSH, OP_LIFO, OP_FIFO: begin
                mem_addr_o <= table_base_i + PTR_OFS;
                mem_re_o   <= 1'b1;
                ret_r      <= S_GPTR;
                state_r    <= S_RWAIT;
              end
              OP_SEARCH: begin
                n_r     <= wtse_bcd(length_i);
                state_r <= S_SCAN;
              end
              OP_MAX: begin
                n_r     <= wtse_bcd(control_i & CTL_LEN_MASK);
                state_r <= S_SCAN;
              end
              default: begin
                state_r <= S_DONE;
              end
            endcase
          end
        end
        S_ZERO: begin
          mem_addr_o  <= cnt_r;
          mem_wdata_o <= '0;
          mem_we_o    <= 1'b1;
          cnt_r       <= cnt_r + 16'h0001;
          if (cnt_r == last_r) begin
            state_r <= S_WBASE;
          end
        end
        S_WBASE: begin
          mem_addr_o  <= tb_r;
          mem_wdata_o <= last_r;
          mem_we_o    <= 1'b1;
          state_r     <= S_WPTR;
        end
        S_WPTR: begin
          mem_addr_o  <= tb_r + PTR_OFS;
          mem_wdata_o <= ptr_r;
          mem_we_o    <= 1'b1;
          state_r     <= S_DONE;
        end
        S_DONE: begin
          done_o  <= 1'b1;
          busy_o  <= 1'b0;
          state_r <= S_IDLE;
        end
        S_RWAIT: begin
          state_r <= ret_r;
        end
        S_GPTR: begin
          if (op_r == OP_PUSH) begin
            ptr_r   <= mem_rdata_i;
            state_r <= S_PUSHW;
          end else if (op_r == OP_LIFO) begin
            ptr_r      <= mem_rdata_i - 16'h0001;
            mem_addr_o <= mem_rdata_i - 16'h0001;
            mem_re_o   <= 1'b1;
            ret_r      <= S_GDAT;
            state_r    <= S_RWAIT;
          end else begin
            ptr_r      <= mem_rdata_i - 16'h0001;
            mem_addr_o <= tb_r;
            mem_re_o   <= 1'b1;
            ret_r      <= S_GBASE;
            state_r    <= S_RWAIT;
          end
        end
        S_PUSHW: begin
          mem_addr_o  <= ptr_r;
          mem_wdata_o <= src_r;
          mem_we_o    <= 1'b1;
          ptr_r       <= ptr_r + 16'h0001;
          state_r     <= S_WPTR;
        end
        S_GBASE: begin
          last_r     <= mem_rdata_i;
          cnt_r      <= tb_r + FIRST_OFS;
          mem_addr_o <= tb_r + FIRST_OFS;
          mem_re_o   <= 1'b1;
          ret_r      <= S_GDAT;
          state_r    <= S_RWAIT;
        end
        S_GDAT: begin
          data_r  <= mem_rdata_i;
          state_r <= S_WDEST;
        end
        S_WDEST: begin
          mem_addr_o  <= dest_r;
          mem_wdata_o <= data_r;
          mem_we_o    <= 1'b1;
          // Last-in pop leaves the stack data untouched.
          state_r     <= (op_r == OP_LIFO) ? S_WPTR : S_SHN;
        end
        S_SHN: begin
          if (cnt_r == last_r) begin
            state_r <= S_WZERO;
          end else begin
            mem_addr_o <= cnt_r + 16'h0001;
            mem_re_o   <= 1'b1;
            ret_r      <= S_SHG;
            state_r    <= S_RWAIT;
          end
        end
        S_SHG: begin
          data_r  <= mem_rdata_i;
          state_r <= S_SHW;
        end
        S_SHW: begin
          mem_addr_o  <= cnt_r;
          mem_wdata_o <= data_r;
          mem_we_o    <= 1'b1;
          cnt_r       <= cnt_r + 16'h0001;
          state_r     <= S_SHN;
        end
        S_WZERO: begin
          mem_addr_o  <= last_r;
          mem_wdata_o <= '0;
          mem_we_o    <= 1'b1;
          state_r     <= S_WPTR;
        end
        S_SCAN: begin
          if (n_r == 16'h0000) begin
            flag_ld_r <= (op_r == OP_SEARCH);
            state_r   <= S_DONE;
          end else begin
            mem_addr_o <= scan_addr;
            mem_re_o   <= 1'b1;
            ret_r      <= S_SGET;
            state_r    <= S_RWAIT;
          end
        end
        S_SGET: begin
          if (op_r == OP_SEARCH) begin
            if (!found_r && mem_rdata_i == cmp_r) begin
              found_r    <= 1'b1;
              best_idx_r <= scan_addr;
            end
          end else if (!found_r || greater) begin
            found_r    <= 1'b1;
            best_r     <= mem_rdata_i;
            best_idx_r <= scan_addr;
          end
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r + 16'h0001 == n_r) begin
            flag_ld_r <= (op_r == OP_SEARCH);
            state_r   <= (op_r == OP_SEARCH) ? S_DONE : S_MAXW;
          end else begin
            state_r <= S_SCAN;
          end
        end
        S_MAXW: begin
          mem_addr_o  <= dest_r;
          mem_wdata_o <= best_r;
          mem_we_o    <= 1'b1;
          idx_ld_r    <= wr_idx_r;
          state_r     <= S_DONE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // Match flag and index register; the engine wins over a port write in
  // the same cycle so a search result is never lost.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      match_flag_o <= 1'b0;
      index_o      <= '0;
    end else begin
      if (flag_ld_r) begin
        match_flag_o <= found_r;
      end
      if ((flag_ld_r && found_r) || idx_ld_r) begin
        index_o <= best_idx_r;
      end else if (reg_wr_i && reg_addr_i == REG_INDEX) begin
        index_o <= reg_wdata_i;
      end
    end
  end

  // Register port. Unmapped addresses read zero; enable gates new starts.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_r    <= CTRL_RST;
      reg_rdata_o <= '0;
    end else begin
      if (reg_wr_i && reg_addr_i == REG_CTRL) begin
        enable_r <= reg_wdata_i[0];
      end
      reg_rdata_o <= '0;
      if (reg_rd_i) begin
        case (reg_addr_i)
          REG_CTRL:  reg_rdata_o <= {15'h0000, enable_r};
          REG_STAT:  reg_rdata_o <= {14'h0000, busy_o, match_flag_o};
          REG_INDEX: reg_rdata_o <= index_o;
          default:   reg_rdata_o <= '0;
        endcase
      end
    end
  end

  // Checks on the memory traffic and result registers.
  ptr_last_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    done_o && op_r != OP_SEARCH && op_r != OP_MAX && op_r <= OP_FIFO
    |-> $past(mem_we_o) && $past(mem_addr_o) == tb_r + PTR_OFS)
    else $error("pointer word was not the last write");
  define_ptr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_r == S_WPTR && op_r == OP_DEFINE |=> mem_we_o
    && mem_addr_o == tb_r + PTR_OFS && mem_wdata_o == tb_r + FIRST_OFS)
    else $error("define wrote a wrong pointer");
  define_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    op_r == OP_DEFINE && busy_o && mem_we_o && mem_addr_o != tb_r
    && mem_addr_o != tb_r + PTR_OFS |-> mem_wdata_o == 16'h0000)
    else $error("define wrote a nonzero data word");
  push_data_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_r == S_PUSHW |=> mem_we_o && mem_addr_o == $past(ptr_r)
    && mem_wdata_o == src_r ##1 mem_we_o && mem_addr_o == tb_r + PTR_OFS
    && mem_wdata_o == $past(mem_addr_o) + 16'h0001)
    else $error("push wrote wrong word or pointer");
  lifo_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    op_r == OP_LIFO && busy_o && mem_we_o
    |-> mem_addr_o == tb_r + PTR_OFS || mem_addr_o == dest_r)
    else $error("last-in pop wrote inside the stack");
  search_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_r == S_SGET && op_r == OP_SEARCH && found_r
    |=> $stable(best_idx_r))
    else $error("later match replaced the lowest one");
  miss_keep_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    flag_ld_r && !found_r && !(reg_wr_i && reg_addr_i == REG_INDEX)
    |=> !match_flag_o && $stable(index_o))
    else $error("miss changed the index or kept the flag");
  max_tie_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_r == S_SGET && op_r == OP_MAX && found_r && !greater
    |=> $stable(best_r) && $stable(best_idx_r))
    else $error("maximum moved without a larger value");
  max_index_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_r == S_MAXW && !wr_idx_r
    |=> !(reg_wr_i && reg_addr_i == REG_INDEX) |=> $stable(index_o))
    else $error("maximum address written while disabled");

  define_c: cover property (@(posedge mclk_i) done_o && op_r == OP_DEFINE);
  fifo_c:   cover property (@(posedge mclk_i) done_o && op_r == OP_FIFO);
  hit_c:    cover property (@(posedge mclk_i) flag_ld_r && found_r);
  max_c:    cover property (@(posedge mclk_i) idx_ld_r);

endmodule : wtse_engine

// ==== wtse_mem.sv ====
`timescale 1ns/10ps
module wtse_mem
  import wtse_pkg::*;
(
  input  wire logic          mclk_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          we_i,
  input  wire logic          re_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] ram [0:255];
  logic          rd_q;
  logic [DW-1:0] rd_val;

  // Writes land on the strobe edge; a read is answered in the next cycle.
  // A plain always block, because the bench preloads the array directly.
  always @(posedge mclk_i) begin
    if (we_i) begin
      ram[addr_i[7:0]] <= wdata_i;
    end
    rd_q <= re_i;
    if (re_i) begin
      rd_val <= ram[addr_i[7:0]];
    end
  end

  // Outside the answer cycle the inverse shows, so late sampling is caught.
  assign rdata_o = rd_q ? rd_val : ~rd_val;
endmodule : wtse_mem

// ==== tb.sv ====
`timescale 1ns/10ps
module tb
  import wtse_pkg::*;
;
  logic          mclk_i = 1'b0;
  logic          rst_n_i = 1'b0;
  logic          start_i = 1'b0;
  logic [2:0]    op_i = 3'h0;
  logic [15:0]   table_base_i = 16'h0000;
  logic [15:0]   length_i = 16'h0000;
  logic [15:0]   source_i = 16'h0000;
  logic [15:0]   range_origin_i = 16'h0000;
  logic [15:0]   compare_value_i = 16'h0000;
  logic [15:0]   control_i = 16'h0000;
  logic [15:0]   dest_addr_i = 16'h0000;
  logic [3:0]    reg_addr_i = 4'h0;
  logic [15:0]   reg_wdata_i = 16'h0000;
  logic          reg_wr_i = 1'b0;
  logic          reg_rd_i = 1'b0;
  logic          busy_o, done_o, mem_we_o, mem_re_o, match_flag_o;
  logic [15:0]   mem_addr_o, mem_wdata_o, mem_rdata_i, index_o;
  logic [15:0]   reg_rdata_o;
  int            num_errors = 0;
  int            n_compared = 0;

  // Free-running 100 MHz clock.
  always #5 mclk_i = ~mclk_i;

  wtse_engine dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_i(op_i),
    .table_base_i(table_base_i), .length_i(length_i),
    .source_i(source_i), .range_origin_i(range_origin_i),
    .compare_value_i(compare_value_i), .control_i(control_i),
    .dest_addr_i(dest_addr_i), .busy_o(busy_o), .done_o(done_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_we_o(mem_we_o), .mem_re_o(mem_re_o), .mem_rdata_i(mem_rdata_i),
    .match_flag_o(match_flag_o), .index_o(index_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));

  wtse_mem mem (
    .mclk_i(mclk_i), .addr_i(mem_addr_o), .wdata_i(mem_wdata_o),
    .we_i(mem_we_o), .re_i(mem_re_o), .rdata_o(mem_rdata_i));

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("Compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One operation; a spends as base or origin, b as length, control or
  // source, c as destination or compare value.
  task automatic run(input logic [2:0] o, input logic [15:0] a, b, c);
    int i;
    @(posedge mclk_i);
    op_i <= o;
    table_base_i <= a;
    range_origin_i <= a;
    length_i <= b;
    control_i <= b;
    source_i <= b;
    dest_addr_i <= c;
    compare_value_i <= c;
    start_i <= 1'b1;
    @(posedge mclk_i);
    start_i <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(negedge mclk_i);
      if (done_o === 1'b1) begin
        chk({13'h0000, busy_o, mem_we_o, mem_re_o}, 16'h0000);
        return;
      end
    end
    num_errors++;
    summarize();
  endtask : run

  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe.
  task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    d = reg_rdata_o;
  endtask : reg_read

  task automatic test_define();
    int i;
    for (i = 'h10; i < 'h18; i++) begin
      mem.ram[i] = 16'hEEEE;
    end
    run(OP_DEFINE, 16'h0010, 16'h0005, 16'h0000);
    for (i = 'h12; i < 'h15; i++) begin
      chk(mem.ram[i], 16'h0000);
    end
    chk(mem.ram['h15], 16'hEEEE);
    chk(mem.ram['h10], 16'h0014);
    chk(mem.ram['h11], 16'h0012);
  endtask : test_define

  task automatic test_stack();
    run(OP_PUSH, 16'h0010, 16'hAAAA, 16'h0000);
    run(OP_PUSH, 16'h0010, 16'hBBBB, 16'h0000);
    chk(mem.ram['h12], 16'hAAAA);
    chk(mem.ram['h13], 16'hBBBB);
    chk(mem.ram['h11], 16'h0014);
    run(OP_LIFO, 16'h0010, 16'h0000, 16'h0040);
    chk(mem.ram['h40], 16'hBBBB);
    chk(mem.ram['h11], 16'h0013);
    chk(mem.ram['h13], 16'hBBBB);
    chk(mem.ram['h10], 16'h0014);
    run(OP_PUSH, 16'h0010, 16'hCCCC, 16'h0000);
    run(OP_PUSH, 16'h0010, 16'hDDDD, 16'h0000);
    run(OP_FIFO, 16'h0010, 16'h0000, 16'h0041);
    chk(mem.ram['h41], 16'hAAAA);
    chk(mem.ram['h12], 16'hCCCC);
    chk(mem.ram['h13], 16'hDDDD);
    chk(mem.ram['h14], 16'h0000);
    chk(mem.ram['h11], 16'h0014);
  endtask : test_stack

  // Register access, then a start while disabled must leave memory alone.
  task automatic test_regs();
    logic [15:0] d;
    reg_read(REG_CTRL, d);
    chk(d, 16'h0001);
    reg_write(REG_INDEX, 16'h1234);
    reg_read(REG_INDEX, d);
    chk(d, 16'h1234);
    reg_read(4'hC, d);
    chk(d, 16'h0000);
    reg_write(REG_CTRL, 16'h0000);
    @(posedge mclk_i);
    op_i <= OP_PUSH;
    start_i <= 1'b1;
    @(posedge mclk_i);
    start_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    @(negedge mclk_i);
    chk({15'h0000, busy_o}, 16'h0000);
    chk(mem.ram['h11], 16'h0014);
    reg_write(REG_CTRL, 16'h0001);
    // An unused op code must finish without touching memory.
    run(3'h6, 16'h0010, 16'h0000, 16'h0010);
    chk(mem.ram['h10], 16'h0014);
    chk(mem.ram['h11], 16'h0014);
  endtask : test_regs

  // A BCD count of 10 must stop before the decoy at 0x6A.
  task automatic test_search();
    int          i;
    logic [15:0] d;
    for (i = 0; i < 16; i++) begin
      mem.ram['h60 + i] = 16'h1000 + 16'(i);
    end
    mem.ram['h63] = 16'h5A5A;
    mem.ram['h69] = 16'h5A5A;
    mem.ram['h6A] = 16'h7777;
    run(OP_SEARCH, 16'h0060, 16'h0010, 16'h5A5A);
    chk({15'h0000, match_flag_o}, 16'h0001);
    chk(index_o, 16'h0063);
    reg_read(REG_STAT, d);
    chk(d, 16'h0001);
    run(OP_SEARCH, 16'h0060, 16'h0010, 16'h7777);
    chk({15'h0000, match_flag_o}, 16'h0000);
    chk(index_o, 16'h0063);
  endtask : test_search

  // Range of 12 words; 0xFFFF just past it must not be seen.
  task automatic test_max();
    int i;
    for (i = 'h70; i < 'h80; i++) begin
      mem.ram[i] = 16'h0100;
    end
    mem.ram['h72] = 16'h8000;
    mem.ram['h74] = 16'h7FFF;
    mem.ram['h76] = 16'h7FFF;
    mem.ram['h7C] = 16'hFFFF;
    run(OP_MAX, 16'h0070, 16'h0012, 16'h0050);
    chk(mem.ram['h50], 16'h8000);
    chk(index_o, 16'h0063);
    run(OP_MAX, 16'h0070, 16'hC012, 16'h0051);
    chk(mem.ram['h51], 16'h7FFF);
    chk(index_o, 16'h0074);
  endtask : test_max

  // Reset is held for six cycles, then the scenarios run in turn.
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    test_define();
    test_stack();
    test_regs();
    test_search();
    test_max();
    summarize();
  end
endmodule : tb
